// >>> rtl/zone_hysteresis_regs.svh
// Constants for the zone classifier and status word
// Notes on behaviour
// [RL1] Value range splits into at most five zones, each with colour and blink.
// [RL2] Top zone has no limit or hysteresis; its upper bound is 9999.
// [RL3] Positive limit: leave zone at limit rising, re-enter below limit minus hysteresis.
// [RL4] Negative limit: leave above limit plus hysteresis, re-enter below limit itself.
// [RL5] Mixed signs combine both behaviours per zone boundary.
// [RL6] Read-only remaining write endurance percentage, zero to one hundred.
// [RL7] Below data-type lower bound shows low-range error and sets status bit 27.
// [RL8] Above data-type upper bound shows high-range error and sets status bit 28.
// [RL9] Non-increasing zone limits show configuration error and set status bit 26; the code compares only neighbouring zone indices that are both enabled.
// [RL10] Hysteresis larger than adjacent limit gap raises configuration error; the code skips enabled zones that have a disabled zone between them.
// [RL11] Safe-state pattern shown after response timeout plus safe-state timeout.
// [RL12] Half-duplex two-wire bus: only one party drives the line at once.
// [RL13] Both parties exchange Modbus frames in RTU or ASCII framing; the code only passes raw bits on busTx and rxData, with no framing.
// [RL14] Zone re-evaluated on each value update from previous zone; drives colour, blink.
// [RL15] Error bits follow their conditions: set while present, cleared when gone.
`ifndef ZONE_HYSTERESIS_REGS_SVH
`define ZONE_HYSTERESIS_REGS_SVH

`define ZONE_COUNT 5
`define ZONE_LIMITED 4
`define ZONE_TOP_BOUND 32'sh0000270F
`define ZONE_BIT_CFG 26
`define ZONE_BIT_LOW 27
`define ZONE_BIT_HIGH 28
`define ZONE_PCT_MAX 7'h64
`define ZONE_CLK_MHZ 125
`define ZONE_MS_CYCLES (`ZONE_CLK_MHZ * 1000)
`define ZONE_STATUS_RESET 32'h00000000
`define ZONE_COLOR_GREEN 2'h0
`define ZONE_TOP_IDX 3'h4
`define ZONE_MS_PER_S 16'h03E8

`endif

// >>> rtl/zone_pkg.sv
// Types shared by the zone classifier modules
`default_nettype none
package zone_pkg;
   typedef logic signed [31:0] value_t;
   typedef logic [2:0] zone_idx_t;
   typedef logic [1:0] color_t;
   typedef enum logic [1:0] {
      SAFE_IDLE = 2'b00,
      SAFE_WAIT_RESP = 2'b01,
      SAFE_WAIT_SAFE = 2'b10,
      SAFE_ACTIVE = 2'b11
   } safe_state_t;
endpackage : zone_pkg
`default_nettype wire

// >>> rtl/zone_cfg_if.sv
// Zone configuration carried from the top into the checker
`default_nettype none
interface zone_cfg_if;
   zone_pkg::value_t limit [4];
   logic [13:0] hyst [4];
   logic [3:0] enable;
   logic cfgError;
   modport top (output limit, output hyst, output enable, input cfgError);
   modport chk (input limit, input hyst, input enable, output cfgError);
endinterface : zone_cfg_if
`default_nettype wire

// >>> rtl/zone_cfg_check.sv
// Checks zone limit ordering and hysteresis against limit gaps
`include "zone_hysteresis_regs.svh"
`default_nettype none
module zone_cfg_check (
   zone_cfg_if.chk cfg
);
   logic [`ZONE_LIMITED-1:0] pairBad;

   genvar g;
   generate
      for (g = 0; g < `ZONE_LIMITED - 1; g++) begin : gPair
         logic signed [32:0] gap;
         assign gap = 33'(cfg.limit[g+1]) - 33'(cfg.limit[g]);
         // Only pairs of enabled zones are compared
         assign pairBad[g] = cfg.enable[g] && cfg.enable[g+1] &&
            ((gap <= 33'sd0) ||                                        // RL9
             ($signed(33'(cfg.hyst[g])) > gap) || ($signed(33'(cfg.hyst[g+1])) > gap)); // RL10
      end
   endgenerate
   assign pairBad[`ZONE_LIMITED-1] = 1'b0;
   assign cfg.cfgError = |pairBad;
endmodule : zone_cfg_check
`default_nettype wire

// >>> rtl/zone_hysteresis_status.sv
// Zone classifier with hysteresis, status word and safe-state timer
`include "zone_hysteresis_regs.svh"
`default_nettype none
module zone_hysteresis_status (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic extEnable,
   input wire logic valueValid,
   input wire zone_pkg::value_t valueIn,
   input wire zone_pkg::value_t typeMin,
   input wire zone_pkg::value_t typeMax,
   input wire logic [3:0] zoneEnable,
   input wire logic [127:0] zoneLimits,
   input wire logic [55:0] zoneHyst,
   input wire logic [9:0] zoneColors,
   input wire logic [4:0] zoneBlink,
   input wire logic [1:0] baseColor,
   input wire logic [15:0] respTimeoutMs,
   input wire logic [15:0] safeTimeoutS,
   input wire logic [6:0] enduranceIn,
   input wire logic busRx,
   input wire logic txRequest,
   input wire logic txData,
   output logic busTx,
   output logic busTxEn_n,
   output logic [2:0] activeZone,
   output logic [1:0] dispColor,
   output logic dispBlink,
   output logic safeDisplay,
   output logic belowRangeError,
   output logic aboveRangeError,
   output logic zoneConfigError,
   output logic [31:0] deviceStatusWord,
   output logic [6:0] enduranceRemaining,
   output logic rxData
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] zone;
      logic [1:0] color;
      logic blink;
      logic [31:0] status;
      logic [6:0] endur;
      zone_pkg::safe_state_t safe;
      logic [31:0] msCnt;
      logic [15:0] unitCnt;
      logic busTx;
      logic busTxEn_n;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // ----------------------------------------
   // Configuration check
   // ----------------------------------------
   zone_cfg_if cfg ();
   zone_pkg::value_t lim [4];
   logic [13:0] hy [4];

   genvar g;
   generate
      for (g = 0; g < `ZONE_LIMITED; g++) begin : gCfg
         assign lim[g] = zone_pkg::value_t'(zoneLimits[32*g +: 32]);
         assign hy[g] = zoneHyst[14*g +: 14];
         assign cfg.limit[g] = lim[g];
         assign cfg.hyst[g] = hy[g];
      end
   endgenerate
   assign cfg.enable = zoneEnable;

   zone_cfg_check uCheck (
      .cfg(cfg)
   );

   // ----------------------------------------
   // Zone boundary thresholds
   // ----------------------------------------
   // Rising exit threshold: reached for positive limits, exceeded over limit+hyst for negative
   function automatic logic risesPast(input zone_pkg::value_t v, input zone_pkg::value_t l,
                                      input logic [13:0] h);
      logic signed [32:0] up;
      up = 33'(l) + $signed(33'(h));
      if (l < 0) begin
         risesPast = 33'(v) > up; // RL4
      end else begin
         risesPast = v >= l; // RL3
      end
   endfunction : risesPast

   // Falling re-entry: below limit-hyst when positive, below limit when negative
   function automatic logic fallsBelow(input zone_pkg::value_t v, input zone_pkg::value_t l,
                                       input logic [13:0] h);
      logic signed [32:0] dn;
      dn = 33'(l) - $signed(33'(h));
      if (l < 0) begin
         fallsBelow = v < l; // RL4
      end else begin
         fallsBelow = 33'(v) < dn; // RL3
      end
   endfunction : fallsBelow

   // Next enabled zone above index i, or the top zone
   function automatic logic [2:0] nextZone(input logic [2:0] i, input logic [3:0] en);
      logic [2:0] r;
      r = 3'h4;
      for (int k = `ZONE_LIMITED - 1; k >= 0; k--) begin
         if (k > int'(i) && en[k]) begin
            r = 3'(k);
         end
      end
      nextZone = r;
   endfunction : nextZone

   // Fresh classification from scratch with rising thresholds
   function automatic logic [2:0] classify(input zone_pkg::value_t v, input logic [3:0] en,
                                           input zone_pkg::value_t l [4], input logic [13:0] h [4]);
      logic [2:0] r;
      r = 3'h4; // RL2
      for (int k = `ZONE_LIMITED - 1; k >= 0; k--) begin
         if (en[k] && !risesPast(v, l[k], h[k])) begin
            r = 3'(k);
         end
      end
      classify = r;
   endfunction : classify

   // Clamp a percentage at one hundred
   function automatic logic [6:0] clampPct(input logic [6:0] p);
      if (p > `ZONE_PCT_MAX) begin
         clampPct = `ZONE_PCT_MAX;
      end else begin
         clampPct = p;
      end
   endfunction : clampPct

   // Colour field of one zone from the packed colour settings
   function automatic logic [1:0] colorOf(input logic [2:0] z, input logic [9:0] c);
      colorOf = c[2*z +: 2];
   endfunction : colorOf

   // ----------------------------------------
   // Per-zone crossing flags
   // ----------------------------------------
   logic [`ZONE_LIMITED-1:0] upPast;
   logic [`ZONE_LIMITED-1:0] downBelow;

   generate
      for (g = 0; g < `ZONE_LIMITED; g++) begin : gCross
         assign upPast[g] = risesPast(valueIn, lim[g], hy[g]); // RL3 RL4
         assign downBelow[g] = fallsBelow(valueIn, lim[g], hy[g]); // RL3 RL4
      end
   endgenerate

   // ----------------------------------------
   // Zone tracking
   // ----------------------------------------
   logic [2:0] zoneNew;
   logic [2:0] curZ;
   always_comb begin
      // RL1 RL5 RL14
      curZ = state_reg.zone;
      zoneNew = curZ;
      if (curZ != 3'h4 && !zoneEnable[curZ[1:0]]) begin
         zoneNew = classify(valueIn, zoneEnable, lim, hy);
      end else begin
         // Climb while above the current zone's exit
         for (int s = 0; s < `ZONE_COUNT; s++) begin
            if (zoneNew != 3'h4 && upPast[zoneNew[1:0]]) begin
               zoneNew = nextZone(zoneNew, zoneEnable);
            end
         end
         // Descend while below a lower zone's re-entry
         for (int s = 0; s < `ZONE_COUNT; s++) begin
            for (int k = `ZONE_LIMITED - 1; k >= 0; k--) begin
               if (zoneEnable[k] && k < int'(zoneNew) &&
                   nextZone(3'(k), zoneEnable) == zoneNew &&
                   downBelow[k]) begin
                  zoneNew = 3'(k);
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Range flags and timer strobes
   // ----------------------------------------
   logic lowErr;
   logic highErr;
   logic overType;
   logic overTop;
   logic tick;
   logic [15:0] safeUnits;
   assign lowErr = valueIn < typeMin;
   assign overType = valueIn > typeMax;
   // Nothing above the top zone's bound is displayable
   assign overTop = valueIn > `ZONE_TOP_BOUND;
   assign highErr = overType || overTop;
   assign tick = state_reg.msCnt == 32'(`ZONE_MS_CYCLES - 1);
   // Safe timeout counted in ms: seconds times 1000
   assign safeUnits = 16'(safeTimeoutS * `ZONE_MS_PER_S);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.msCnt = tick ? 32'h0 : state_reg.msCnt + 32'h1;
      if (valueValid) begin
         state_next.zone = extEnable ? zoneNew : 3'h4; // RL14
         state_next.status[`ZONE_BIT_LOW] = lowErr; // RL7 RL15
         state_next.status[`ZONE_BIT_HIGH] = highErr; // RL8 RL15
      end
      state_next.status[`ZONE_BIT_CFG] = extEnable && cfg.cfgError; // RL9 RL10 RL15
      if (extEnable) begin
         state_next.color = colorOf(state_next.zone, zoneColors);
         state_next.blink = zoneBlink[state_next.zone];
      end else begin
         state_next.color = baseColor;
         state_next.blink = 1'b0;
      end
      // RL6
      state_next.endur = clampPct(enduranceIn);
      // RL11
      if (valueValid) begin
         state_next.safe = zone_pkg::SAFE_WAIT_RESP;
         state_next.unitCnt = 16'h0;
         state_next.msCnt = 32'h0;
      end else begin
         unique case (state_reg.safe)
            zone_pkg::SAFE_IDLE: begin
            end
            zone_pkg::SAFE_WAIT_RESP: begin
               if (tick) begin
                  state_next.unitCnt = state_reg.unitCnt + 16'h1;
                  if (state_reg.unitCnt + 16'h1 >= respTimeoutMs) begin
                     state_next.safe = zone_pkg::SAFE_WAIT_SAFE;
                     state_next.unitCnt = 16'h0;
                  end
               end
            end
            zone_pkg::SAFE_WAIT_SAFE: begin
               if (safeUnits == 16'h0 || (tick && state_reg.unitCnt + 16'h1 >= safeUnits)) begin
                  state_next.safe = zone_pkg::SAFE_ACTIVE;
               end else if (tick) begin
                  state_next.unitCnt = state_reg.unitCnt + 16'h1;
               end
            end
            zone_pkg::SAFE_ACTIVE: begin
            end
         endcase
      end
      // RL12 RL13: line driven from the cycle after txRequest is sampled high, released the cycle after it is sampled low
      state_next.busTxEn_n = !txRequest;
      state_next.busTx = txRequest ? txData : 1'b1;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= '{zone: `ZONE_TOP_IDX,
                        color: `ZONE_COLOR_GREEN,
                        blink: 1'b0,
                        status: `ZONE_STATUS_RESET,
                        endur: 7'h0,
                        safe: zone_pkg::SAFE_IDLE,
                        msCnt: 32'h0,
                        unitCnt: 16'h0,
                        busTx: 1'b1,
                        busTxEn_n: 1'b1};
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign activeZone = state_reg.zone;
   assign dispColor = state_reg.color;
   assign dispBlink = state_reg.blink;
   assign safeDisplay = state_reg.safe == zone_pkg::SAFE_ACTIVE; // RL11
   assign deviceStatusWord = state_reg.status;
   assign belowRangeError = state_reg.status[`ZONE_BIT_LOW]; // RL7
   assign aboveRangeError = state_reg.status[`ZONE_BIT_HIGH]; // RL8
   assign zoneConfigError = state_reg.status[`ZONE_BIT_CFG]; // RL9
   assign enduranceRemaining = state_reg.endur;

   // ----------------------------------------
   // Bus pins
   // ----------------------------------------
   assign busTx = state_reg.busTx;
   assign busTxEn_n = state_reg.busTxEn_n; // RL12
   assign rxData = busRx;
endmodule : zone_hysteresis_status
`default_nettype wire

// >>> verif/zone_hysteresis_status_assertions.sv
// Port assertions for the zone classifier
`include "zone_hysteresis_regs.svh"
`default_nettype none
module zone_hysteresis_status_assertions (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic extEnable,
   input wire logic valueValid,
   input wire zone_pkg::value_t valueIn,
   input wire zone_pkg::value_t typeMin,
   input wire zone_pkg::value_t typeMax,
   input wire logic [3:0] zoneEnable,
   input wire logic [127:0] zoneLimits,
   input wire logic [6:0] enduranceIn,
   input wire logic txRequest,
   input wire logic txData,
   input wire logic busTx,
   input wire logic busTxEn_n,
   input wire logic [2:0] activeZone,
   input wire logic safeDisplay,
   input wire logic belowRangeError,
   input wire logic aboveRangeError,
   input wire logic zoneConfigError,
   input wire logic [31:0] deviceStatusWord,
   input wire logic [6:0] enduranceRemaining
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_low_flag: assert property (valueValid && valueIn < typeMin |=> belowRangeError)
      else $error("low range flag missing");
   a_high_flag: assert property (valueValid && (valueIn > typeMax || valueIn > `ZONE_TOP_BOUND)
      |=> aboveRangeError) else $error("high range flag missing");
   a_range_clear: assert property (valueValid && valueIn >= typeMin && valueIn <= typeMax
      && valueIn <= `ZONE_TOP_BOUND |=> !belowRangeError && !aboveRangeError) else $error("range flag stuck");
   a_status_map: assert property (deviceStatusWord ==
      {3'h0, aboveRangeError, belowRangeError, zoneConfigError, 26'h0}) else $error("status word mismatch");
   a_order_error: assert property (extEnable && zoneEnable[1:0] == 2'h3
      && $signed(zoneLimits[63:32]) <= $signed(zoneLimits[31:0])
      |=> zoneConfigError) else $error("order error missed");
   a_rise_exit: assert property (valueValid && extEnable && zoneEnable == 4'h1 && activeZone == 3'h0
      && $signed(zoneLimits[31:0]) > 0 && valueIn >= $signed(zoneLimits[31:0]) |=> activeZone == 3'h4)
      else $error("zone not left at limit");
   a_safe_clear: assert property (valueValid |=> !safeDisplay) else $error("safe display stuck");
   a_endur_clamp: assert property (!rst |=> enduranceRemaining ==
      ($past(enduranceIn) > 7'h64 ? 7'h64 : $past(enduranceIn))) else $error("endurance wrong");
   a_tx_follow: assert property (!rst |=> busTxEn_n == !$past(txRequest)
      && busTx == ($past(txRequest) ? $past(txData) : 1'b1)) else $error("bus driver wrong");
endmodule : zone_hysteresis_status_assertions
bind zone_hysteresis_status zone_hysteresis_status_assertions i_checker (.sys_clk, .rst, .extEnable, .valueValid,
   .valueIn, .typeMin, .typeMax, .zoneEnable, .zoneLimits, .enduranceIn, .txRequest, .txData, .busTx, .busTxEn_n,
   .activeZone, .safeDisplay, .belowRangeError, .aboveRangeError, .zoneConfigError, .deviceStatusWord,
   .enduranceRemaining);
`default_nettype wire

// >>> verif/modbus_party_model.sv
// Remote bus party sending one serial character on request
`default_nettype none
module modbus_party_model (
   input wire logic sys_clk,
   input wire logic busTxEn_n,
   input wire logic talk,
   input wire logic [7:0] charIn,
   output logic busRx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lineLevel = 1'b1;
   logic [8:0] shiftReg = 9'h1FF;
   logic [3:0] bitsLeft = 4'h0;
   assign busRx = lineLevel;
   always @(posedge sys_clk) begin
      if (talk && busTxEn_n && bitsLeft == 4'h0) begin
         lineLevel <= 1'b0;
         shiftReg <= {1'b1, charIn};
         bitsLeft <= 4'h9;
      end else if (bitsLeft != 4'h0) begin
         lineLevel <= shiftReg[0];
         shiftReg <= {1'b1, shiftReg[8:1]};
         bitsLeft <= bitsLeft - 4'h1;
      end else begin
         // Released line rests at the biased idle level
         lineLevel <= 1'b1;
      end
   end
endmodule : modbus_party_model
`default_nettype wire

// >>> verif/zone_hysteresis_status_tb.sv
// Self-checking bench for the zone classifier
`default_nettype none
module zone_hysteresis_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst = 1'b1, extEnable = 1'b1, valueValid = 1'b0;
   logic txRequest = 1'b0, txData = 1'b1, talk = 1'b0;
   zone_pkg::value_t valueIn = '0, typeMin = -999, typeMax = 32767;
   logic [3:0] zoneEnable = 4'h0;
   logic [127:0] zoneLimits = '0;
   logic [55:0] zoneHyst = '0;
   logic [9:0] zoneColors = 10'h201;
   logic [4:0] zoneBlink = 5'h01;
   logic [1:0] baseColor = 2'h1, dispColor;
   logic [15:0] respTimeoutMs = 16'h0001, safeTimeoutS = 16'h0000;
   logic [6:0] enduranceIn = 7'h37, enduranceRemaining;
   logic busRx, busTx, busTxEn_n, dispBlink, safeDisplay, rxData, belowRangeError, aboveRangeError, zoneConfigError;
   logic [2:0] activeZone;
   logic [31:0] deviceStatusWord;
   int miscompares = 0, nChecks = 0;
   zone_hysteresis_status i_zone_hysteresis_status (.sys_clk, .rst, .extEnable, .valueValid, .valueIn, .typeMin,
      .typeMax, .zoneEnable, .zoneLimits, .zoneHyst, .zoneColors, .zoneBlink, .baseColor, .respTimeoutMs,
      .safeTimeoutS, .enduranceIn, .busRx, .txRequest, .txData, .busTx, .busTxEn_n, .activeZone, .dispColor,
      .dispBlink, .safeDisplay, .belowRangeError, .aboveRangeError, .zoneConfigError, .deviceStatusWord,
      .enduranceRemaining, .rxData);
   modbus_party_model i_modbus_party_model (.sys_clk, .busTxEn_n, .talk, .charIn(8'hA5), .busRx);
   initial forever #4 sys_clk = ~sys_clk;
   task automatic complete_run();
      $display("checks %0d miscompares %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic upd(input zone_pkg::value_t v);
      @(posedge sys_clk);
      valueIn <= v;
      valueValid <= 1'b1;
      @(posedge sys_clk);
      valueValid <= 1'b0;
      #1;
   endtask : upd
   task automatic seq(input zone_pkg::value_t v [8], input logic [2:0] z [8]);
      for (int i = 0; i < 8; i++) begin
         upd(v[i]);
         chk("activeZone", 32'(activeZone), 32'(z[i]));
      end
   endtask : seq
   task automatic cfg(input logic [3:0] en, input zone_pkg::value_t l0, l1, input logic [13:0] h0, h1);
      @(posedge sys_clk);
      zoneEnable <= en;
      zoneLimits <= {64'h0, l1, l0};
      zoneHyst <= {28'h0, h1, h0};
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : cfg
   task automatic zone_scenario();
      cfg(4'h1, 100, 0, 14'hA, 14'h0);
      seq('{50, 99, 100, 90, 89, 95, 99, 100}, '{3'h0, 3'h0, 3'h4, 3'h4, 3'h0, 3'h0, 3'h0, 3'h4});
      chk("dispColor", 32'(dispColor), 32'h2);
      cfg(4'h3, -150, -100, 14'h14, 14'hA);
      seq('{-200, -130, -129, -89, -100, -101, -150, -151}, '{3'h0, 3'h0, 3'h1, 3'h4, 3'h4, 3'h1, 3'h1, 3'h0});
      cfg(4'h3, -100, 100, 14'hA, 14'hA);
      seq('{-90, -89, 99, 100, 90, 89, -100, -101}, '{3'h0, 3'h1, 3'h1, 3'h4, 3'h4, 3'h1, 3'h1, 3'h0});
      chk("dispBlink", 32'(dispBlink), 32'h1);
   endtask : zone_scenario
   task automatic range_scenario();
      upd(-1000);
      chk("status", deviceStatusWord, 32'h08000000);
      upd(10000);
      chk("status", deviceStatusWord, 32'h10000000);
      upd(9999);
      chk("status", deviceStatusWord, 32'h0);
      @(posedge sys_clk);
      typeMax <= 9000;
      upd(9001);
      chk("aboveRangeError", 32'(aboveRangeError), 32'h1);
      cfg(4'h3, 100, 100, 14'h0, 14'h0);
      chk("status", deviceStatusWord, 32'h14000000);
      cfg(4'h3, -100, 100, 14'hC9, 14'h0);
      chk("zoneConfigError", 32'(zoneConfigError), 32'h1);
      cfg(4'h3, -100, 100, 14'hC8, 14'h0);
      chk("zoneConfigError", 32'(zoneConfigError), 32'h0);
   endtask : range_scenario
   task automatic misc_scenario();
      logic [9:0] frame = {1'b1, 8'hA5, 1'b0};
      chk("endurance", 32'(enduranceRemaining), 32'h37);
      @(posedge sys_clk);
      enduranceIn <= 7'h78;
      extEnable <= 1'b0;
      upd(5);
      chk("endurance", 32'(enduranceRemaining), 32'h64);
      chk("dispColor", 32'(dispColor), 32'h1);
      chk("activeZone", 32'(activeZone), 32'h4);
      @(posedge sys_clk);
      extEnable <= 1'b1;
      txRequest <= 1'b1;
      txData <= 1'b0;
      @(posedge sys_clk);
      txRequest <= 1'b0;
      talk <= 1'b1;
      #1;
      chk("busTxEn_n", 32'({busTxEn_n, busTx}), 32'h0);
      @(posedge sys_clk);
      #1;
      chk("busTxEn_n", 32'({busTxEn_n, busTx}), 32'h3);
      @(posedge sys_clk);
      talk <= 1'b0;
      #1;
      for (int i = 0; i < 10; i++) begin
         chk("rxData", 32'(rxData), 32'(frame[i]));
         @(posedge sys_clk);
         #1;
      end
   endtask : misc_scenario
   task automatic safe_scenario();
      upd(0);
      repeat (124000) @(posedge sys_clk);
      #1;
      chk("safeDisplay", 32'(safeDisplay), 32'h0);
      for (int i = 0; i < 3000 && safeDisplay !== 1'b1; i++) @(posedge sys_clk);
      #1;
      chk("safeDisplay", 32'(safeDisplay), 32'h1);
      if (safeDisplay !== 1'b1) complete_run();
      upd(1);
      chk("safeDisplay", 32'(safeDisplay), 32'h0);
   endtask : safe_scenario
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      zone_scenario();
      range_scenario();
      misc_scenario();
      safe_scenario();
      complete_run();
   end
endmodule : zone_hysteresis_status_tb
`default_nettype wire
